// file: core/cam_if_pkg.sv
// constants shared by the cam positioner host link ends
// assumes one common clock for both ends
package cam_if_pkg;
  localparam logic [7:0] code_write = 8'h10;
  localparam logic [7:0] code_del_one = 8'h20;
  localparam logic [7:0] code_del_all = 8'h30;
  localparam logic [3:0] id_cmd = 4'h1;
  localparam logic [3:0] id_on = 4'h2;
  localparam logic [3:0] id_off = 4'h3;
  localparam int req_bit = 9;
  localparam int host_ack_bit = 15;
  localparam int dev_ack_bit = 15;
  localparam int ready_bit = 7;
  localparam logic [11:0] err_none = 12'h000;
  localparam logic [11:0] err_dup = 12'h023;
  localparam logic [11:0] err_onoff = 12'h022;
  localparam logic [11:0] err_input = 12'h021;
  localparam logic [11:0] err_full = 12'h024;
  localparam logic [1:0] mode_two_word = 2'h0;
  localparam logic [1:0] mode_four_word = 2'h1;
  localparam logic [15:0] word_zero = 16'h0000;
endpackage : cam_if_pkg

// file: core/cam_link_if.sv
// io words between controller cpu and cam positioner
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface cam_link_if;
  logic [15:0] blk_word0;
  logic [15:0] blk_word1;
  logic [15:0] blk_word2;
  logic blk_strobe;
  logic [15:0] data_word;
  logic [15:0] ctrl_word;
  logic [15:0] rd_word0;
  logic [15:0] rd_word1;
  logic [15:0] rd_word2;
  logic [15:0] stat_word;
  modport device_end (
    input blk_word0, blk_word1, blk_word2, blk_strobe, data_word, ctrl_word,
    output rd_word0, rd_word1, rd_word2, stat_word
  );
  modport host_end (
    output blk_word0, blk_word1, blk_word2, blk_strobe, data_word, ctrl_word,
    input rd_word0, rd_word1, rd_word2, stat_word
  );
endinterface : cam_link_if
`default_nettype wire

// file: core/cam_host_end.sv
// controller cpu end: issues blocks in two- or four-word mode
// assumes device end on the same clk through cam_link_if
`timescale 1ns/1ps
`default_nettype none
module cam_host_end (
  input wire logic clk,
  input wire logic rst_b,
  cam_link_if.host_end link,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata
);
  typedef enum {h_idle, h_put, h_req, h_ack, h_wrdy} hstate_type;
  hstate_type st_r;
  logic [15:0] w_r [3];
  logic four_r;
  logic busy_r;
  logic [1:0] idx_r;
  logic [15:0] data_r;
  logic req_r;
  logic hack_r;
  logic strobe_r;
  logic [15:0] rdata_r;
  // 0..2 block words, 3 ctrl: bit0 go, bit1 four-word mode
  wire go = wr && (addr == 2'h3) && wdata[0] && !busy_r;
  wire dev_ack = link.stat_word[cam_if_pkg::dev_ack_bit];
  wire dev_rdy = link.stat_word[cam_if_pkg::ready_bit];
  wire is_all = (w_r[0][15:8] == cam_if_pkg::code_del_all);
  // four-word command word: tens digit of the code minus one, 0 = write;
  // the code's units digit does not travel in this mode
  wire [3:0] cmd_digit = w_r[0][15:12] - 4'h1;
  wire [15:0] tx0 = {cam_if_pkg::id_cmd, cmd_digit, w_r[0][7:0]};
  // unused angle words still carry their id digit, angle field zero
  wire [15:0] tx1 = is_all ? {cam_if_pkg::id_on, 12'h000}
                   : {cam_if_pkg::id_on, w_r[1][11:0]};
  wire [15:0] tx2 = is_all ? {cam_if_pkg::id_off, 12'h000}
                   : {cam_if_pkg::id_off, w_r[2][11:0]};
  wire [15:0] tx_sel = (idx_r == 2'h0) ? tx0 : (idx_r == 2'h1) ? tx1 : tx2;
  ////////////////////////////////////////////////////////////////////////
  assign link.blk_word0 = w_r[0];
  assign link.blk_word1 = is_all ? cam_if_pkg::word_zero : w_r[1];
  assign link.blk_word2 = is_all ? cam_if_pkg::word_zero : w_r[2];
  assign link.blk_strobe = strobe_r;
  assign link.data_word = data_r;
  assign link.ctrl_word = {hack_r, 5'h00, req_r, 9'h000};
  assign rdata = rdata_r;
  wire [15:0] status = {13'h0000, dev_rdy, four_r, busy_r};
  wire [15:0] rmux = (addr == 2'h0) ? link.rd_word0
                   : (addr == 2'h1) ? link.rd_word1
                   : (addr == 2'h2) ? link.rd_word2 : status;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      w_r <= '{default: 16'h0000};
      four_r <= 1'b0;
      rdata_r <= 16'h0000;
    end
    else
    begin
      if (wr && addr != 2'h3 && !busy_r)
        w_r[addr] <= wdata;
      if (go)
        four_r <= wdata[1];
      rdata_r <= rd ? rmux : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= h_idle;
      busy_r <= 1'b0;
      idx_r <= 2'h0;
      data_r <= 16'h0000;
      req_r <= 1'b0;
      hack_r <= 1'b0;
      strobe_r <= 1'b0;
    end
    else
    begin
      strobe_r <= 1'b0;
      case (st_r)
        h_idle:
        begin
          hack_r <= 1'b0;
          if (go && !wdata[1])
          begin
            strobe_r <= 1'b1;
          end
          else if (go)
          begin
            busy_r <= 1'b1;
            idx_r <= 2'h0;
            st_r <= h_put;
          end
        end
        h_put:
        begin
          hack_r <= 1'b0;
          data_r <= tx_sel;
          if (!dev_ack && dev_rdy)
            st_r <= h_req;
        end
        h_req:
        begin
          req_r <= 1'b1;
          st_r <= h_ack;
        end
        h_ack:
          if (dev_ack)
          begin
            hack_r <= 1'b1;
            req_r <= 1'b0;
            st_r <= h_wrdy;
          end
        h_wrdy:
          // wait for the device to finish before the next word
          if (!dev_ack && dev_rdy)
          begin
            hack_r <= 1'b0;
            if (idx_r == 2'h2)
            begin
              busy_r <= 1'b0;
              st_r <= h_idle;
            end
            else
            begin
              idx_r <= idx_r + 2'h1;
              st_r <= h_put;
            end
          end
        default: st_r <= h_idle;
      endcase
    end
  end
endmodule : cam_host_end
`default_nettype wire

// file: core/cam_device_end.sv
// cam positioner end: step table, command decode, read words
// assumes host end on same clk; outputs/angle come from the cam core
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cam_device_end #(
  parameter int steps = 16,
  parameter int proc_cycles = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  cam_link_if.device_end link,
  input wire logic [31:0] out_state,
  input wire logic [11:0] cur_angle,
  output logic [11:0] err_code,
  output logic [7:0] step_count
);
  typedef enum {d_idle, d_cap, d_exec, d_wait} dstate_type;
  dstate_type st_r;
  logic vld_r [steps];
  logic [7:0] out_r [steps];
  logic [11:0] on_r [steps];
  logic [11:0] off_r [steps];
  logic [15:0] cw_r;
  logic [11:0] ona_r;
  logic [11:0] offa_r;
  logic [11:0] err_r;
  logic ack_r;
  logic rdy_r;
  logic [1:0] widx_r;
  logic [7:0] cnt_r;
  logic [15:0] rd0_r;
  logic [15:0] rd1_r;
  logic [15:0] rd2_r;
  function automatic logic bcd_ok(input logic [11:0] v);
    bcd_ok = (v[3:0] < 4'ha) && (v[7:4] < 4'ha) && (v[11:8] < 4'ha);
  endfunction : bcd_ok
  ////////////////////////////////////////////////////////////////////////
  wire [7:0] code = cw_r[15:8];
  wire [7:0] onum = cw_r[7:0];
  wire code_ok = (code == cam_if_pkg::code_write)
              || (code == cam_if_pkg::code_del_one)
              || (code == cam_if_pkg::code_del_all);
  // OFF angle only checked on write
  wire in_ok = code_ok && bcd_ok({4'h0, onum}) && bcd_ok(ona_r)
            && (code != cam_if_pkg::code_write || bcd_ok(offa_r));
  logic dup;
  logic clash;
  logic free_hit;
  int free_ix;
  always_comb
  begin
    dup = 1'b0;
    clash = 1'b0;
    free_hit = 1'b0;
    free_ix = 0;
    for (int i = 0; i < steps; i++)
    begin
      if (vld_r[i] && out_r[i] == onum && on_r[i] == ona_r
          && off_r[i] == offa_r)
        dup = 1'b1;
      if (vld_r[i] && out_r[i] == onum
          && (on_r[i] == ona_r || off_r[i] == offa_r
              || on_r[i] == offa_r || off_r[i] == ona_r))
        clash = 1'b1;
      if (!vld_r[i] && !free_hit)
      begin
        free_hit = 1'b1;
        free_ix = i;
      end
    end
  end
  wire [7:0] cnt_init = 8'(proc_cycles);
  ////////////////////////////////////////////////////////////////////////
  assign link.rd_word0 = rd0_r;
  assign link.rd_word1 = rd1_r;
  assign link.rd_word2 = rd2_r;
  assign link.stat_word = {ack_r, 7'h00, rdy_r, 7'h00};
  assign err_code = err_r;
  always_comb
  begin
    step_count = 8'h00;
    for (int i = 0; i < steps; i++)
      step_count = step_count + {7'h00, vld_r[i]};
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd0_r <= 16'h0000;
      rd1_r <= 16'h0000;
      rd2_r <= 16'h0000;
    end
    else
    begin
      rd0_r <= out_state[15:0];
      rd1_r <= out_state[31:16];
      rd2_r <= {4'h0, cur_angle};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  wire req = link.ctrl_word[cam_if_pkg::req_bit];
  wire hack = link.ctrl_word[cam_if_pkg::host_ack_bit];
  wire [3:0] wid = link.data_word[15:12];
  // rebuild the full code from the digit sent in four-word mode
  wire [15:0] cmd_four = {link.data_word[11:8] + 4'h1, 4'h0,
                          link.data_word[7:0]};
  wire [3:0] want = (widx_r == 2'h0) ? cam_if_pkg::id_cmd
                  : (widx_r == 2'h1) ? cam_if_pkg::id_on : cam_if_pkg::id_off;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= d_idle;
      vld_r <= '{default: 1'b0};
      out_r <= '{default: 8'h00};
      on_r <= '{default: 12'h000};
      off_r <= '{default: 12'h000};
      cw_r <= 16'h0000;
      ona_r <= 12'h000;
      offa_r <= 12'h000;
      err_r <= cam_if_pkg::err_none;
      ack_r <= 1'b0;
      rdy_r <= 1'b1;
      widx_r <= 2'h0;
      cnt_r <= 8'h00;
    end
    else
    begin
      case (st_r)
        d_idle:
          if (link.blk_strobe)
          begin
            cw_r <= link.blk_word0;
            ona_r <= link.blk_word1[11:0];
            offa_r <= link.blk_word2[11:0];
            rdy_r <= 1'b0;
            st_r <= d_exec;
          end
          else if (req && !ack_r)
          begin
            if (wid != want)
            begin
              err_r <= cam_if_pkg::err_input;
              widx_r <= 2'h0;
            end
            else if (widx_r == 2'h0)
              cw_r <= cmd_four;
            else if (widx_r == 2'h1)
              ona_r <= link.data_word[11:0];
            else
              offa_r <= link.data_word[11:0];
            ack_r <= 1'b1;
            rdy_r <= 1'b0;
            st_r <= d_cap;
          end
        d_cap:
          if (hack && !req)
          begin
            ack_r <= 1'b0;
            if (widx_r == 2'h2)
            begin
              widx_r <= 2'h0;
              st_r <= d_exec;
            end
            else
            begin
              if (err_r != cam_if_pkg::err_input || wid == want)
                widx_r <= widx_r + 2'h1;
              rdy_r <= 1'b1;
              st_r <= d_idle;
            end
          end
        d_exec:
        begin
          // one pass decides the command, then the busy count runs
          begin
            cnt_r <= cnt_init;
            st_r <= d_wait;
            if (!in_ok)
              err_r <= cam_if_pkg::err_input;
            else if (code == cam_if_pkg::code_write)
            begin
              if (dup)
                err_r <= cam_if_pkg::err_dup;
              else if (clash)
                err_r <= cam_if_pkg::err_onoff;
              else if (!free_hit)
                err_r <= cam_if_pkg::err_full;
              else
              begin
                vld_r[free_ix] <= 1'b1;
                out_r[free_ix] <= onum;
                on_r[free_ix] <= ona_r;
                off_r[free_ix] <= offa_r;
                err_r <= cam_if_pkg::err_none;
              end
            end
            else
            begin
              for (int i = 0; i < steps; i++)
                if (vld_r[i] && out_r[i] == onum
                    && (code == cam_if_pkg::code_del_all
                        || on_r[i] == ona_r))
                  vld_r[i] <= 1'b0;
              err_r <= cam_if_pkg::err_none;
            end
          end
        end
        d_wait:
          if (cnt_r <= 8'h01)
          begin
            rdy_r <= 1'b1;
            st_r <= d_idle;
          end
          else
            cnt_r <= cnt_r - 8'h01;
        default: st_r <= d_idle;
      endcase
    end
  end
endmodule : cam_device_end
`default_nettype wire

// file: test/cam_link_sva.sv
// checker on the io words between the two cam link ends
// assumes one clk shared by both ends, rst_b async low
`timescale 1ns/1ps
`default_nettype none
module cam_link_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] blk_word1,
  input wire logic [15:0] blk_word2,
  input wire logic [15:0] blk_word0,
  input wire logic blk_strobe,
  input wire logic [15:0] data_word,
  input wire logic [15:0] ctrl_word,
  input wire logic [15:0] rd_word2,
  input wire logic [15:0] stat_word
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  wire logic req = ctrl_word[9];
  wire logic hack = ctrl_word[15];
  wire logic dack = stat_word[15];
  wire logic rdy = stat_word[7];
  sequence s_idle_req;
    req && rdy && !dack;
  endsequence
  // ack may only drop once the host has answered
  sequence s_ack_open;
    dack && !(hack && !req);
  endsequence
  ack_on_req_a: assert property (s_idle_req |=> dack)
    else $error("no ack after request");
  ack_hold_a: assert property (s_ack_open |=> dack)
    else $error("ack dropped early");
  busy_on_ack_a: assert property ($rose(dack) |-> ##[0:1] !rdy)
    else $error("ready stayed high on ack");
  ready_back_a: assert property ($fell(rdy) |-> ##[1:40] rdy)
    else $error("ready not restored");
  block_busy_a: assert property (blk_strobe && rdy |=> !rdy)
    else $error("block not taken");
  zero_fill_a: assert property (blk_strobe && blk_word0[15:8] == 8'h30
    |-> blk_word1 == 16'h0 && blk_word2 == 16'h0)
    else $error("unused words not zero");
  one_pulse_a: assert property (blk_strobe |=> !blk_strobe)
    else $error("trigger longer than one cycle");
  data_first_a: assert property ($rose(req) |-> $stable(data_word))
    else $error("data changed with request");
  req_drop_a: assert property ($fell(req) |-> $past(dack))
    else $error("request cleared before ack");
  word_id_a: assert property ($rose(req) |-> data_word[15:12] inside
    {4'h1, 4'h2, 4'h3})
    else $error("bad word id");
  angle_top_a: assert property (rd_word2[15:12] == 4'h0)
    else $error("angle word top bits set");
endmodule : cam_link_sva
`default_nettype wire

// file: test/tb.sv
// self-checking bench: host end and device end joined by cam_link_if
// assumes a 125 MHz clk and the designer's control word at addr 3
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst_b, wr, rd;
  logic [1:0] addr;
  logic [15:0] wdata, rdata, s;
  logic [31:0] out_state;
  logic [11:0] cur_angle, err_code;
  logic [7:0] step_count;
  logic [31:0] q[$];
  int err_total, n_tests, cyc, seed, v;
  cam_link_if link ();
  cam_host_end u_cam_host_end (.clk(clk), .rst_b(rst_b), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  cam_device_end #(.steps(16), .proc_cycles(4)) u_cam_device_end (
    .clk(clk), .rst_b(rst_b), .link(link), .out_state(out_state),
    .cur_angle(cur_angle), .err_code(err_code), .step_count(step_count));
  cam_link_sva u_cam_link_sva (.clk(clk), .rst_b(rst_b),
    .blk_word0(link.blk_word0), .blk_word1(link.blk_word1),
    .blk_word2(link.blk_word2), .blk_strobe(link.blk_strobe),
    .data_word(link.data_word), .ctrl_word(link.ctrl_word),
    .rd_word2(link.rd_word2), .stat_word(link.stat_word));
  ////////////////////////////////////////
  task results;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task chk_w(input logic [15:0] g, input logic [15:0] x);
    n_tests++;
    if (g !== x)
    begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk_w
  task chk_e(input logic [11:0] g, input logic [11:0] x);
    chk_w({4'h0, g}, {4'h0, x});
  endtask : chk_e
  function automatic logic [11:0] bcd(input int x);
    return {4'(x / 100), 4'(x / 10 % 10), 4'(x % 10)};
  endfunction : bcd
  // step table as the device should hold it: {output, on, off}
  function automatic logic [11:0] model(input logic [15:0] c,
    input logic [11:0] a, input logic [11:0] b);
    logic [31:0] w;
    w = {c[7:0], a, b};
    case (c[15:8])
      8'h10:
      begin
        foreach (q[i]) if (q[i] === w) return cam_if_pkg::err_dup;
        // any angle shared with a stored step of that output is refused
        foreach (q[i])
          if (q[i][31:24] === w[31:24] && (q[i][23:12] === a
              || q[i][11:0] === b || q[i][23:12] === b
              || q[i][11:0] === a))
            return cam_if_pkg::err_onoff;
        q.push_back(w);
      end
      // bit 12 set only for the erase-all code: angle not compared
      8'h20, 8'h30:
        for (int i = q.size() - 1; i >= 0; i--)
          if (q[i][31:24] === w[31:24] && (c[12] || q[i][23:12] === a))
            q.delete(i);
      default: return cam_if_pkg::err_input;
    endcase
    return cam_if_pkg::err_none;
  endfunction : model
  task wr_t(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_t
  task rd_t(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 s = rdata;
  endtask : rd_t
  task go(input logic [15:0] c, input logic [11:0] a, input logic [11:0] b,
    input logic m, input logic bad);
    logic [11:0] x;
    x = bad ? cam_if_pkg::err_input : model(c, a, b);
    wr_t(2'h0, c);
    wr_t(2'h1, {4'h0, a});
    wr_t(2'h2, {4'h0, b});
    wr_t(2'h3, {14'h0, m, 1'b1});
    s = 16'h0;
    for (int k = 0; k < 100 && (s[2] !== 1'b1 || s[0] !== 1'b0); k++)
      rd_t(2'h3);
    chk_w(s & 16'h0005, 16'h0004);
    chk_e(err_code, x);
    chk_e({4'h0, step_count}, 12'(q.size()));
  endtask : go
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // a hang cuts the run short through the same report
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    seed = 32'h5c0c;
    rst_b = 1'b0;
    {wr, rd, addr, wdata, out_state, cur_angle} = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd_t(2'h3);
    chk_w(s, 16'h0004);
    for (int i = 0; i < 6; i++)
    begin
      v = $unsigned($random(seed)) % 100;
      go({8'h10, 8'(i)}, bcd(v), bcd(v + 1 + i), 1'b0, 1'b0);
    end
    go({8'h10, q[0][31:24]}, q[0][23:12], q[0][11:0], 1'b0, 1'b0);
    go({8'h10, q[0][31:24]}, q[0][23:12], 12'h350, 1'b0, 1'b0);
    go(16'h1000, 12'h300, 12'h310, 1'b0, 1'b0);
    go(16'h2000, 12'h300, 12'h999, 1'b0, 1'b0);
    go(16'h3001, 12'h000, 12'h000, 1'b0, 1'b0);
    go(16'h4002, 12'h010, 12'h020, 1'b0, 1'b0);
    go(16'h101a, 12'h010, 12'h020, 1'b0, 1'b1);
    go(16'h1003, 12'h0a0, 12'h020, 1'b0, 1'b1);
    go(16'h1009, 12'h100, 12'h120, 1'b1, 1'b0);
    go(16'h1012, 12'h200, 12'h250, 1'b0, 1'b0);
    out_state <= $random(seed);
    cur_angle <= bcd($unsigned($random(seed)) % 360);
    repeat (3) @(posedge clk);
    rd_t(2'h0);
    chk_w(s, out_state[15:0]);
    rd_t(2'h1);
    chk_w(s, out_state[31:16]);
    rd_t(2'h2);
    chk_w(s, {4'h0, cur_angle});
    results();
  end
endmodule : tb
`default_nettype wire
